// [test/shmc_adc_model.sv]
`timescale 1ns/10ps
// Converter stand-in: each code names its channel, so every analog value register is traceable.
module shmc_adc_model (
  input  wire logic       i_clk,  // Clock.
  input  wire logic [4:0] i_chan, // Channel in conversion.
  output logic      [7:0] o_code  // Result code.
);
  // The code settles one cycle after the channel changes, well before sampling.
  always_ff @(posedge i_clk) o_code <= {i_chan, 3'b011};
endmodule : shmc_adc_model

// [test/shmc_core_properties.sv]
`timescale 1ns/10ps
// Watches bus handshake, conversion pacing and rail reset outputs.
module shmc_chk (
  input wire logic                    i_clk,                  // Clock.
  input wire logic                    i_rst_b,                // Reset, active low.
  input wire shmc_pkg::shmc_avs_req_t i_avs_req,              // Bus request.
  input wire logic                    o_avs_waitrequest,      // Bus wait.
  input wire logic                    o_adc_start,            // Start pulse.
  input wire logic [4:0]              o_adc_chan,             // Channel.
  input wire logic                    o_adc_diode,            // Long conversion.
  input wire logic                    i_main_low,             // Main rail low.
  input wire logic                    i_stby_low,             // Standby rail low.
  input wire logic                    o_main_rail_reset_oe,   // Main reset driven.
  input wire logic                    o_standby_rail_reset_b, // Standby reset.
  input wire logic [7:0]              o_dac_code              // DAC code.
);
  logic [5:0] rel_ff;
  // Counts cycles since reset release, saturating.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) rel_ff <= '0;
    else if (rel_ff != 6'd63) rel_ff <= rel_ff + 6'd1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  wait_answer_a: assert property ((i_avs_req.read || i_avs_req.write) && o_avs_waitrequest |=>
    !o_avs_waitrequest) else $error("Bus request not answered.");
  wait_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("Wait low too long.");
  start_pulse_a: assert property (o_adc_start |=> !o_adc_start) else $error("Start not a pulse.");
  short_conv_a: assert property (o_adc_start && o_adc_chan < 5'd17 |-> ##20 o_adc_start &&
    o_adc_chan == $past(o_adc_chan, 20) + 5'd1) else $error("Short conversion order or length wrong.");
  long_conv_a: assert property (o_adc_start && o_adc_diode |-> ##60 o_adc_start) else $error("Long conversion.");
  rail_hold_a: assert property (rel_ff < 6'd49 |-> o_main_rail_reset_oe && !o_standby_rail_reset_b)
    else $error("Power-up reset pulse too short.");
  main_low_a: assert property (i_main_low |-> ##[1:4] o_main_rail_reset_oe) else $error("Main reset missed.");
  stby_low_a: assert property (i_stby_low |-> ##[1:4] !o_standby_rail_reset_b) else $error("Standby reset.");
  dac_hold_a: assert property (!i_avs_req.write && !$past(i_avs_req.write) |=> $stable(o_dac_code))
    else $error("DAC code moved.");
endmodule : shmc_chk
bind shmc_core shmc_chk u_chk (.*);

// [test/tb.sv]
`timescale 1ns/10ps
// Drives the core over the bus and compares with results worked out from channel numbers.
module tb;
  logic i_clk, i_rst_b, i_bat_rst_b, i_intrusion, i_main_low, i_stby_low, ext_b;
  logic o_avs_waitrequest, o_adc_start, o_adc_diode, o_main_rail_reset, o_main_rail_reset_oe;
  logic o_standby_rail_reset_b, o_fan_pwm, o_fan_pwm_oe, o_int;
  logic [31:0] o_avs_readdata, q;
  logic [4:0]  o_adc_chan;
  logic [7:0]  i_adc_code, i_tach, o_dac_code, lim;
  logic [16:0] i_gpio, o_gpio, o_gpio_oe;
  logic [1:0]  i_addr_sel;
  shmc_pkg::shmc_avs_req_t i_avs_req;
  int err_total, compares, cyc;
  wire logic i_main_rail_reset = ext_b & ~o_main_rail_reset_oe;
  shmc_core #(.SHORT_CYC(20), .LONG_CYC(60), .PULSE_CYC(50), .FAN_BASE(4)) DUT (.*);
  shmc_adc_model u_adc (.i_clk(i_clk), .i_chan(o_adc_chan), .o_code(i_adc_code));
  // ==========================================================================
  // Tasks
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      err_total++;
    end
  endtask : chk
  // One bus transfer, held until wait is seen low; data is taken at that edge.
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    i_avs_req <= '{read: !w, write: w, address: a, writedata: d};
    @(posedge i_clk);
    while (o_avs_waitrequest !== 1'b0) @(posedge i_clk);
    q = o_avs_readdata;
    i_avs_req <= '0;
    repeat (2) @(posedge i_clk);
  endtask : bus
  task results;
    $display("Counts: compares=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  // Clock generator.
  initial begin
    i_clk = 0;
    forever #50 i_clk = ~i_clk;
  end
  // Cuts a hang short.
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(32'hc4e7));
    i_addr_sel = 2'($urandom % 3);
    {i_rst_b, i_intrusion, i_main_low, i_stby_low} = '0;
    {i_bat_rst_b, ext_b} = 2'b01;
    {i_tach, i_gpio, i_avs_req, cyc, err_total, compares} = '0;
    repeat (16) @(posedge i_clk);
    {i_rst_b, i_bat_rst_b} <= 2'b11;
    // The address pins are captured a few cycles after reset, so that register is read second.
    bus(0, 4'hF, 0);
    chk(q, 0);
    bus(0, shmc_pkg::REG_SLV_ADDR, 0);
    chk(q, {shmc_pkg::SLV_ADDR_HI, i_addr_sel});
    repeat (60) @(posedge i_clk);
    chk({o_main_rail_reset_oe, o_standby_rail_reset_b}, 2'b01);
    {i_main_low, i_stby_low} <= 2'b11;
    repeat (5) @(posedge i_clk);
    chk({o_main_rail_reset_oe, o_standby_rail_reset_b}, 2'b10);
    {i_main_low, i_stby_low} <= 2'b00;
    repeat (60) @(posedge i_clk);
    bus(1, shmc_pkg::REG_CFG, 2);
    ext_b <= 0;
    repeat (5) @(posedge i_clk);
    ext_b <= 1;
    repeat (3) @(posedge i_clk);
    bus(0, shmc_pkg::REG_CFG, 0);
    chk(q, 0);
    $display("Reset and rail tests done.");
    bus(1, shmc_pkg::REG_CFG, 1);
    lim = 8'($urandom % 8'h1B);
    bus(1, shmc_pkg::REG_PTR, 8'h23);
    bus(1, shmc_pkg::REG_DATA, lim);
    repeat (600) @(posedge i_clk);
    // Each analog value register holds its channel's code.
    for (int ch = 0; ch < 21; ch++) begin
      bus(1, shmc_pkg::REG_PTR, ch);
      bus(0, shmc_pkg::REG_DATA, 0);
      chk(q, 32'(8 * ch + 3));
    end
    bus(0, shmc_pkg::REG_STATUS, 0);
    chk(q, 32'h0000_0008);
    chk(o_int, 1);
    bus(1, shmc_pkg::REG_MASK, 8);
    chk(o_int, 0);
    bus(1, shmc_pkg::REG_MASK, 0);
    chk(o_int, 1);
    bus(1, shmc_pkg::REG_PTR, 8'h23);
    bus(1, shmc_pkg::REG_DATA, 8'hFF);
    bus(1, shmc_pkg::REG_STATUS, 8);
    chk(o_int, 0);
    $display("Measurement tests done.");
    i_intrusion <= 1;
    repeat (4) @(posedge i_clk);
    i_intrusion <= 0;
    bus(0, shmc_pkg::REG_STATUS, 0);
    chk(q, 32'h2000_0000);
    chk(o_int, 1);
    bus(1, shmc_pkg::REG_FAN_DRV, {16'h0000, lim, 8'hFF});
    chk({o_dac_code, o_fan_pwm_oe}, {lim, 1'b0});
    // Pins get a random level well before the input register is read.
    i_gpio <= 17'($urandom);
    bus(1, shmc_pkg::REG_GPIO_POL, 32'h0001_2345);
    bus(1, shmc_pkg::REG_GPIO_DIR, 32'h0000_F0F0);
    bus(1, shmc_pkg::REG_GPIO_OUT, 32'h0000_00FF);
    bus(0, shmc_pkg::REG_GPIO_IN, 0);
    chk(q, 32'(i_gpio ^ 17'h1_2345));
    chk(o_gpio, 32'h0001_23BA);
    chk(o_gpio_oe, 32'h0000_F0F0);
    // Diode mode: channel 19 runs long and the auxiliary channel is skipped.
    bus(1, shmc_pkg::REG_CFG, 3);
    while (!(o_adc_start && o_adc_chan == 5'h13)) @(posedge i_clk);
    chk(o_adc_diode, 1);
    @(posedge i_clk);
    while (!o_adc_start) @(posedge i_clk);
    chk(o_adc_chan, 0);
    // A stalled fan saturates its counter and reads full scale.
    repeat (300) @(posedge i_clk);
    bus(1, shmc_pkg::REG_PTR, 8'h15);
    bus(0, shmc_pkg::REG_DATA, 0);
    chk(q, 32'h0000_00FF);
    $display("Intrusion, fan, GPIO and mode tests done.");
    results();
  end
endmodule : tb

// [verilog/shmc_core.sv]
`timescale 1ns/10ps
// Behaviour
// - When running, convert analog and temperature channels in turn; fans measured in parallel.
// - Each finished result goes into its own value register, readable any time.
// - Every stored result is compared with its limits; a violation sets a status bit.
// - Any unmasked out-of-limit result raises the interrupt output.
// - Each status bit has a mask bit; masked bits never raise the interrupt.
// - Chassis intrusion latches into a bit kept by the battery-backed reset.
// - Both rail reset outputs pulse 180 ms at power-up and assert on low supply.
// - Main rail reset pin driven low externally clears pointer, config, mask and the limit status bits (not intrusion) and stops measurement.
// - Fan PWM output runs at 75 Hz with host-programmed duty.
// - Host-programmed 8-bit code feeds the fan DAC.
// - A write to the pointer word loads a register address into the pointer.
// - Analog and internal conversions last 11.38 ms, remote diode ones 34.13 ms.
// - Fan counts span two tach pulses, one revolution.
// - Analog results are 8-bit codes.
// - Each fan counter prescale comes from a host divisor register.
// - Each GPIO has programmable direction and polarity.
// - A config bit selects remote diode or two analog channels on pins two.
// - Bus slave address is fixed upper five bits plus two select-pin bits.
module shmc_core #(
  parameter int SHORT_CYC  = shmc_pkg::SHORT_CONV_CYC,
  parameter int LONG_CYC   = shmc_pkg::LONG_CONV_CYC,
  parameter int PULSE_CYC  = shmc_pkg::RAIL_PULSE_CYC,
  parameter int FAN_BASE   = shmc_pkg::FAN_BASE_CYC,
  parameter int N_GPIO     = 17
) (
  input  wire logic                   i_clk,              // Device clock.
  input  wire logic                   i_rst_b,            // Async reset, active low.
  input  wire logic                   i_bat_rst_b,        // Battery domain reset, active low.
  input  wire shmc_pkg::shmc_avs_req_t i_avs_req,          // Avalon request.
  output logic [31:0]                 o_avs_readdata,     // Avalon read data.
  output logic                        o_avs_waitrequest,  // Avalon wait request.
  output logic [4:0]                  o_adc_chan,         // Channel being converted.
  output logic                        o_adc_start,        // Conversion start pulse.
  output logic                        o_adc_diode,        // Remote diode conversion.
  input  wire logic [7:0]             i_adc_code,         // Converter result.
  input  wire logic [7:0]             i_tach,             // Fan tach pins.
  input  wire logic                   i_intrusion,        // Chassis intrusion pin.
  input  wire logic                   i_main_low,         // Main rail below threshold.
  input  wire logic                   i_stby_low,         // Standby rail below threshold.
  input  wire logic                   i_main_rail_reset,  // Main rail reset pin level.
  output logic                        o_main_rail_reset,  // Main rail reset pin data.
  output logic                        o_main_rail_reset_oe, // Main pin pulled low.
  output logic                        o_standby_rail_reset_b, // Standby reset, active low.
  output logic                        o_fan_pwm,          // PWM pin data.
  output logic                        o_fan_pwm_oe,       // PWM pin pulled low.
  output logic [7:0]                  o_dac_code,         // Fan DAC code.
  input  wire logic [N_GPIO-1:0]      i_gpio,             // GPIO pin levels.
  output logic [N_GPIO-1:0]           o_gpio,             // GPIO output data.
  output logic [N_GPIO-1:0]           o_gpio_oe,          // GPIO output enables.
  input  wire logic [1:0]             i_addr_sel,         // Address select pin code.
  output logic                        o_int               // Interrupt, active high.
);

  // ==========================================================================
  // Parameter checks
  if (N_GPIO < 1 || N_GPIO > 32 || SHORT_CYC < 1 || LONG_CYC < 1 || PULSE_CYC < 1
      || FAN_BASE < 1) begin : g_chk
    $error("shmc_core: unsupported parameter value");
  end

  localparam int NS  = shmc_pkg::N_STAT;
  localparam int NC  = shmc_pkg::N_CH;
  localparam int NSY = 8 + 4 + 2 + N_GPIO;

  // Conversion length of a channel in clock cycles.
  function automatic logic [31:0] conv_len(input logic [4:0] ch, input logic diode2);
    conv_len = is_long(ch, diode2) ? LONG_CYC[31:0] : SHORT_CYC[31:0];
  endfunction : conv_len

  // Remote diode channels take the long conversion.
  function automatic logic is_long(input logic [4:0] ch, input logic diode2);
    is_long = (ch == shmc_pkg::CH_REMOTE1) || (ch == shmc_pkg::CH_REMOTE2 && diode2);
  endfunction : is_long

  // Next channel of the sequence; the auxiliary input is skipped in diode mode.
  function automatic logic [4:0] next_ch(input logic [4:0] ch, input logic diode2);
    logic [4:0] n;
    n = ch + 5'h01;
    if (n == shmc_pkg::CH_AUX && diode2) begin
      n = shmc_pkg::CH_FAN0;
    end
    if (n >= shmc_pkg::CH_FAN0) begin
      n = '0;
    end
    next_ch = n;
  endfunction : next_ch

  // Result outside the window of its limits.
  function automatic logic out_of_lim(input logic [7:0] v, input logic [7:0] hi, input logic [7:0] lo);
    out_of_lim = (v > hi) || (v < lo);
  endfunction : out_of_lim

  // ==========================================================================
  // Input synchronisers
  logic [NSY-1:0] sync1_ff;
  logic [NSY-1:0] sync2_ff;
  logic [7:0]     tach_d_ff;

  // Two flops before any logic reads a pin.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_ff  <= '0;
      sync2_ff  <= '0;
      tach_d_ff <= '0;
    end else begin
      sync1_ff  <= {i_gpio, i_addr_sel, i_intrusion, i_main_low, i_stby_low, i_main_rail_reset, i_tach};
      sync2_ff  <= sync1_ff;
      tach_d_ff <= sync2_ff[7:0];
    end
  end

  wire [7:0]        tach_s     = sync2_ff[7:0];
  wire              mpin_s     = sync2_ff[8];
  wire [1:0]        low_s      = {sync2_ff[9], sync2_ff[10]};
  wire              intr_s     = sync2_ff[11];
  wire [1:0]        asel_s     = sync2_ff[13:12];
  wire [N_GPIO-1:0] gpio_s     = sync2_ff[NSY-1:14];
  wire [7:0]        tach_rise  = tach_s & ~tach_d_ff;

  // ==========================================================================
  // Rail resets
  logic [31:0] rail_cnt_ff [2];
  logic [1:0]  rail_act_ff;
  logic [2:0]  oe_hist_ff;
  logic        nxt_rail_busy [2];
  logic [31:0] nxt_rail_cnt [2];

  // Each timer reloads while its rail is low and counts out the pulse after.
  always_comb begin
    for (int r = 0; r < 2; r++) begin
      nxt_rail_cnt[r]  = low_s[r] ? PULSE_CYC[31:0] :
                         (rail_cnt_ff[r] != '0) ? rail_cnt_ff[r] - 32'h0000_0001 : rail_cnt_ff[r];
      nxt_rail_busy[r] = low_s[r] || (nxt_rail_cnt[r] != '0);
    end
  end

  // External low on the main pin, ignored while our own drive may still echo.
  wire ext_rst = !mpin_s && (oe_hist_ff == '0) && !rail_act_ff[0];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rail_cnt_ff[0] <= PULSE_CYC[31:0];
      rail_cnt_ff[1] <= PULSE_CYC[31:0];
      rail_act_ff    <= 2'h3;
      oe_hist_ff     <= 3'h7;
    end else begin
      rail_cnt_ff[0] <= nxt_rail_cnt[0];
      rail_cnt_ff[1] <= nxt_rail_cnt[1];
      rail_act_ff    <= {nxt_rail_busy[1], nxt_rail_busy[0]};
      oe_hist_ff     <= {oe_hist_ff[1:0], rail_act_ff[0]};
    end
  end

  assign o_main_rail_reset_oe   = rail_act_ff[0];
  assign o_main_rail_reset      = 1'h0;
  assign o_standby_rail_reset_b = !rail_act_ff[1];

  // ==========================================================================
  // Avalon slave: one wait cycle, then answer
  logic        wait_ff;
  logic [31:0] rdata_ff;
  logic [7:0]  ptr_ff;
  logic [1:0]  cfg_ff;
  logic [NS-1:0] mask_ff;
  logic [15:0] fdiv_ff;
  logic [15:0] drv_ff;
  logic [N_GPIO-1:0] gdir_ff;
  logic [N_GPIO-1:0] gpol_ff;
  logic [N_GPIO-1:0] gout_ff;
  logic [NS-1:0] stat_ff;
  logic        intr_ff;
  logic [6:0]  slv_ff;
  logic [1:0]  cap_ff;
  logic [7:0]  val_ff [NC];
  logic [7:0]  hi_ff [NC];
  logic [7:0]  lo_ff [NC];
  shmc_pkg::shmc_seq_t seq_ff;
  logic [4:0]  chan_ff;

  wire        req      = i_avs_req.read | i_avs_req.write;
  wire        take     = req & wait_ff;
  wire        wr       = i_avs_req.write & ~wait_ff;
  wire [3:0]  adr      = i_avs_req.address;
  wire [31:0] wd       = i_avs_req.writedata;
  wire [2:0]  bank     = ptr_ff[7:5];
  wire [4:0]  pidx     = ptr_ff[4:0];
  wire        pidx_ok  = (pidx < 5'(NC));
  wire        wr_ptr   = wr && adr == shmc_pkg::REG_PTR;
  wire        wr_data  = wr && adr == shmc_pkg::REG_DATA && pidx_ok;
  wire        wr_stat  = wr && adr == shmc_pkg::REG_STATUS;
  wire [NS-1:0] w1c    = wr_stat ? wd[NS-1:0] : '0;
  wire        run      = cfg_ff[shmc_pkg::CFG_RUN_BIT] && !ext_rst;
  wire        diode2   = cfg_ff[shmc_pkg::CFG_DIODE2_BIT];

  // Byte selected by the address pointer.
  wire [7:0] ptr_byte = !pidx_ok ? 8'h00 :
                        (bank == shmc_pkg::BANK_VAL) ? val_ff[pidx] :
                        (bank == shmc_pkg::BANK_HI)  ? hi_ff[pidx] :
                        (bank == shmc_pkg::BANK_LO)  ? lo_ff[pidx] : 8'h00;

  logic [31:0] rd_mux;

  // Read data selection; unmapped words read zero.
  always_comb begin
    rd_mux = '0;
    unique case (adr)
      shmc_pkg::REG_PTR:      rd_mux[7:0]        = ptr_ff;
      shmc_pkg::REG_DATA:     rd_mux[7:0]        = ptr_byte;
      shmc_pkg::REG_CFG:      rd_mux[1:0]        = cfg_ff;
      shmc_pkg::REG_STATUS:   rd_mux[NS-1:0]     = {intr_ff, stat_ff[NC-1:0]};
      shmc_pkg::REG_MASK:     rd_mux[NS-1:0]     = mask_ff;
      shmc_pkg::REG_FAN_DIV:  rd_mux[15:0]       = fdiv_ff;
      shmc_pkg::REG_FAN_DRV:  rd_mux[15:0]       = drv_ff;
      shmc_pkg::REG_GPIO_DIR: rd_mux[N_GPIO-1:0] = gdir_ff;
      shmc_pkg::REG_GPIO_POL: rd_mux[N_GPIO-1:0] = gpol_ff;
      shmc_pkg::REG_GPIO_OUT: rd_mux[N_GPIO-1:0] = gout_ff;
      shmc_pkg::REG_GPIO_IN:  rd_mux[N_GPIO-1:0] = gpio_s ^ gpol_ff;
      shmc_pkg::REG_SLV_ADDR: rd_mux[6:0]        = slv_ff;
      shmc_pkg::REG_SEQ:      rd_mux[5:0]        = {seq_ff, chan_ff};
      default:                rd_mux             = '0;
    endcase
  end

  // Handshake and software-owned registers; an external reset clears pointer, config and mask only.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_ff  <= 1'h1;
      rdata_ff <= '0;
      ptr_ff   <= '0;
      cfg_ff   <= '0;
      mask_ff  <= '0;
      fdiv_ff  <= '0;
      drv_ff   <= '0;
      gdir_ff  <= '0;
      gpol_ff  <= '0;
      gout_ff  <= '0;
    end else begin
      wait_ff  <= !take;
      rdata_ff <= (take && i_avs_req.read) ? rd_mux : rdata_ff;
      if (ext_rst) begin
        ptr_ff  <= '0;
        cfg_ff  <= '0;
        mask_ff <= '0;
      end else begin
        if (wr_ptr) ptr_ff <= wd[7:0];
        if (wr && adr == shmc_pkg::REG_CFG) cfg_ff <= wd[1:0];
        if (wr && adr == shmc_pkg::REG_MASK) mask_ff <= wd[NS-1:0];
      end
      if (wr && adr == shmc_pkg::REG_FAN_DIV) fdiv_ff <= wd[15:0];
      if (wr && adr == shmc_pkg::REG_FAN_DRV) drv_ff <= wd[15:0];
      if (wr && adr == shmc_pkg::REG_GPIO_DIR) gdir_ff <= wd[N_GPIO-1:0];
      if (wr && adr == shmc_pkg::REG_GPIO_POL) gpol_ff <= wd[N_GPIO-1:0];
      if (wr && adr == shmc_pkg::REG_GPIO_OUT) gout_ff <= wd[N_GPIO-1:0];
    end
  end

  assign o_avs_waitrequest = wait_ff;
  assign o_avs_readdata    = rdata_ff;

  // ==========================================================================
  // Slave address capture: sampled for the first three cycles after reset, then locked
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cap_ff <= '0;
      slv_ff <= '0;
    end else if (cap_ff != 2'h3) begin
      cap_ff <= cap_ff + 2'h1;
      slv_ff <= {shmc_pkg::SLV_ADDR_HI, asel_s};
    end
  end

  // ==========================================================================
  // Conversion sequencer
  logic [31:0] tmr_ff;
  logic        start_ff;
  logic        diode_ff;

  wire        seq_done = (seq_ff == shmc_pkg::SEQ_CONV) && (tmr_ff == '0);
  wire        seq_go   = run && ((seq_ff == shmc_pkg::SEQ_IDLE) || seq_done);
  wire [4:0]  ch_nxt   = (seq_ff == shmc_pkg::SEQ_IDLE) ? '0 : next_ch(chan_ff, diode2);
  wire shmc_pkg::shmc_seq_t nxt_seq = seq_go ? shmc_pkg::SEQ_CONV :
                                      seq_done ? shmc_pkg::SEQ_IDLE : seq_ff;
  wire [31:0] nxt_tmr  = seq_go ? conv_len(ch_nxt, diode2) - 32'h0000_0001 :
                         (tmr_ff != '0) ? tmr_ff - 32'h0000_0001 : tmr_ff;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      seq_ff   <= shmc_pkg::SEQ_IDLE;
      chan_ff  <= '0;
      tmr_ff   <= '0;
      start_ff <= 1'h0;
      diode_ff <= 1'h0;
    end else begin
      seq_ff   <= nxt_seq;
      chan_ff  <= seq_go ? ch_nxt : chan_ff;
      tmr_ff   <= nxt_tmr;
      start_ff <= seq_go;
      diode_ff <= seq_go ? is_long(ch_nxt, diode2) : diode_ff;
    end
  end

  assign o_adc_chan  = chan_ff;
  assign o_adc_start = start_ff;
  assign o_adc_diode = diode_ff;

  // ==========================================================================
  // Fan speed counters
  logic [15:0] base_ff;
  logic [2:0]  pre_ff [shmc_pkg::N_FAN];
  logic [7:0]  fcnt_ff [shmc_pkg::N_FAN];
  logic [7:0]  ph_ff;
  logic [7:0]  ftick;
  logic [7:0]  fstore;
  logic [7:0]  fval [shmc_pkg::N_FAN];

  wire base_tick = run && (base_ff == 16'(FAN_BASE - 1));

  // Prescaled tick per fan; a result is stored every second tach pulse.
  always_comb begin
    for (int f = 0; f < shmc_pkg::N_FAN; f++) begin
      ftick[f]  = base_tick && (pre_ff[f] == 3'((1 << fdiv_ff[2*f +: 2]) - 1));
      fstore[f] = run && ((tach_rise[f] && ph_ff[f]) ||
                  (ftick[f] && fcnt_ff[f] == shmc_pkg::VAL_MAX));
      fval[f]   = (tach_rise[f] && ph_ff[f]) ? fcnt_ff[f] : shmc_pkg::VAL_MAX;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      base_ff <= '0;
      ph_ff   <= '0;
      for (int f = 0; f < shmc_pkg::N_FAN; f++) begin
        pre_ff[f]  <= '0;
        fcnt_ff[f] <= '0;
      end
    end else begin
      base_ff <= (!run || base_tick) ? '0 : base_ff + 16'h0001;
      ph_ff   <= run ? ph_ff ^ tach_rise : '0;
      for (int f = 0; f < shmc_pkg::N_FAN; f++) begin
        pre_ff[f]  <= !base_tick ? pre_ff[f] : ftick[f] ? '0 : pre_ff[f] + 3'h1;
        fcnt_ff[f] <= (!run || fstore[f]) ? '0 :
                      (ftick[f] && fcnt_ff[f] != shmc_pkg::VAL_MAX) ? fcnt_ff[f] + 8'h01 : fcnt_ff[f];
      end
    end
  end

  // ==========================================================================
  // Value store, limit compare and status
  logic [NC-1:0] st_we;
  logic [7:0]    st_val [NC];
  logic [NC-1:0] set_vec;

  // One write port per channel: the sequencer or its fan counter.
  always_comb begin
    for (int c = 0; c < NC; c++) begin
      st_we[c]  = seq_done && (chan_ff == 5'(c));
      st_val[c] = i_adc_code;
      if (c >= shmc_pkg::N_ANA) begin
        st_we[c]  = fstore[c - shmc_pkg::N_ANA];
        st_val[c] = fval[c - shmc_pkg::N_ANA];
      end
      set_vec[c] = st_we[c] && out_of_lim(st_val[c], hi_ff[c], lo_ff[c]);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int c = 0; c < NC; c++) begin
        val_ff[c] <= '0;
        hi_ff[c]  <= shmc_pkg::LIM_HI_RST;
        lo_ff[c]  <= shmc_pkg::LIM_LO_RST;
      end
    end else begin
      for (int c = 0; c < NC; c++) begin
        if (st_we[c]) val_ff[c] <= st_val[c];
        if (wr_data && pidx == 5'(c) && bank == shmc_pkg::BANK_HI) hi_ff[c] <= wd[7:0];
        if (wr_data && pidx == 5'(c) && bank == shmc_pkg::BANK_LO) lo_ff[c] <= wd[7:0];
      end
    end
  end

  // Sticky status: a set in the clearing cycle wins.
  wire [NS-1:0] nxt_stat = ext_rst ? '0 : {1'h0, (stat_ff[NC-1:0] & ~w1c[NC-1:0]) | set_vec};
  wire          nxt_intr = (intr_ff & ~w1c[shmc_pkg::INTR_BIT]) | intr_s;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stat_ff <= '0;
      o_int   <= 1'h0;
    end else begin
      stat_ff <= nxt_stat;
      o_int   <= |({nxt_intr, nxt_stat[NC-1:0]} & ~mask_ff);
    end
  end

  // Intrusion flag lives on the battery reset only.
  always_ff @(posedge i_clk or negedge i_bat_rst_b) begin
    if (!i_bat_rst_b) begin
      intr_ff <= 1'h0;
    end else begin
      intr_ff <= nxt_intr;
    end
  end

  // ==========================================================================
  // Fan drive and GPIO outputs
  logic [15:0] pstep_ff;
  logic [7:0]  phase_ff;

  wire pwm_step = (pstep_ff == 16'(shmc_pkg::PWM_STEP_CYC - 1));

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pstep_ff     <= '0;
      phase_ff     <= '0;
      o_fan_pwm_oe <= 1'h1;
      o_dac_code   <= '0;
      o_gpio       <= '0;
      o_gpio_oe    <= '0;
    end else begin
      pstep_ff     <= pwm_step ? '0 : pstep_ff + 16'h0001;
      phase_ff     <= pwm_step ? phase_ff + 8'h01 : phase_ff;
      o_fan_pwm_oe <= phase_ff >= drv_ff[7:0];
      o_dac_code   <= drv_ff[shmc_pkg::DRV_DAC_LSB +: 8];
      o_gpio       <= gout_ff ^ gpol_ff;
      o_gpio_oe    <= gdir_ff;
    end
  end

  assign o_fan_pwm = 1'h0;

endmodule : shmc_core

// [verilog/shmc_pkg.sv]
package shmc_pkg;

  // ==========================================================================
  // Timing
  localparam real CLK_PERIOD_NS = 100.0;
  localparam real SHORT_CONV_MS = 11.38;
  localparam real LONG_CONV_MS  = 34.13;
  localparam real RAIL_PULSE_MS = 180.0;
  localparam real PWM_FREQ_HZ   = 75.0;
  localparam int  PWM_STEPS     = 256;
  localparam int  SHORT_CONV_CYC = int'(SHORT_CONV_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int  LONG_CONV_CYC  = int'(LONG_CONV_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int  RAIL_PULSE_CYC = int'(RAIL_PULSE_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int  PWM_STEP_CYC   = $rtoi(1.0e9 / (PWM_FREQ_HZ * CLK_PERIOD_NS * PWM_STEPS));
  localparam int  FAN_BASE_CYC   = 444;

  // ==========================================================================
  // Channels and status layout
  localparam int          CW         = 5;
  localparam int          N_ANA      = 21;
  localparam int          N_FAN      = 8;
  localparam int          N_CH       = N_ANA + N_FAN;
  localparam int          INTR_BIT   = N_CH;
  localparam int          N_STAT     = N_CH + 1;
  localparam logic [4:0]  CH_REMOTE1 = 5'h12;
  localparam logic [4:0]  CH_REMOTE2 = 5'h13;
  localparam logic [4:0]  CH_AUX     = 5'h14;
  localparam logic [4:0]  CH_FAN0    = 5'h15;
  localparam logic [7:0]  VAL_MAX    = 8'hFF;
  localparam logic [7:0]  LIM_HI_RST = 8'hFF;
  localparam logic [7:0]  LIM_LO_RST = 8'h00;

  // ==========================================================================
  // Register word indices
  localparam logic [3:0] REG_PTR      = 4'h0;
  localparam logic [3:0] REG_DATA     = 4'h1;
  localparam logic [3:0] REG_CFG      = 4'h2;
  localparam logic [3:0] REG_STATUS   = 4'h3;
  localparam logic [3:0] REG_MASK     = 4'h4;
  localparam logic [3:0] REG_FAN_DIV  = 4'h5;
  localparam logic [3:0] REG_FAN_DRV  = 4'h6;
  localparam logic [3:0] REG_GPIO_DIR = 4'h7;
  localparam logic [3:0] REG_GPIO_POL = 4'h8;
  localparam logic [3:0] REG_GPIO_OUT = 4'h9;
  localparam logic [3:0] REG_GPIO_IN  = 4'hA;
  localparam logic [3:0] REG_SLV_ADDR = 4'hB;
  localparam logic [3:0] REG_SEQ      = 4'hC;

  // Field positions.
  localparam int         CFG_RUN_BIT    = 0;
  localparam int         CFG_DIODE2_BIT = 1;
  localparam int         DRV_DAC_LSB    = 8;
  localparam logic [2:0] BANK_VAL       = 3'h0;
  localparam logic [2:0] BANK_HI        = 3'h1;
  localparam logic [2:0] BANK_LO        = 3'h2;
  localparam logic [4:0] SLV_ADDR_HI    = 5'h0B;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } shmc_avs_req_t;

  typedef enum logic {
    SEQ_IDLE = 1'h0,
    SEQ_CONV = 1'h1
  } shmc_seq_t;

endpackage : shmc_pkg
